// ---- tscs_pkg.sv ----
// constants of the touch scan control and status block
package tscs_pkg;

	// -----------------------------------------------------------
	// register indices, byte address is four times the index
	// -----------------------------------------------------------
	localparam logic [7:0] IDX_CS0 = 8'h08;
	localparam logic [7:0] IDX_CS1 = 8'h09;
	localparam logic [7:0] IDX_CS3 = 8'h0B;
	localparam logic [7:0] IDX_CNT_HI = 8'h0C;
	localparam logic [7:0] IDX_CNT_LO = 8'h0D;
	localparam logic [7:0] IDX_EVT_STAT = 8'h10;
	localparam logic [7:0] IDX_EVT_MASK = 8'h11;

	// -----------------------------------------------------------
	// control/status 0 bit positions
	// -----------------------------------------------------------
	localparam int B_ENABLE = 7;
	localparam int B_IRQ_EN = 6;
	localparam int B_STOP_EN = 5;
	localparam int B_TRIG_MODE = 4;
	localparam int B_IN_PROG = 3;
	localparam int B_EOS = 2;
	localparam int B_SWAP = 1;
	localparam int B_SW_START = 0;

	// -----------------------------------------------------------
	// field widths and reset values
	// -----------------------------------------------------------
	localparam int CH_W = 4;
	localparam int EVT_W = 2;
	localparam int EV_DONE = 0;
	localparam int EV_DROP = 1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [CH_W-1:0] RST_CH = 4'h0;
	localparam logic [EVT_W-1:0] RST_EVT = 2'h0;

	// -----------------------------------------------------------
	// trigger mode encoding
	// -----------------------------------------------------------
	localparam logic MODE_SW = 1'b0;
	localparam logic MODE_HW = 1'b1;

	typedef enum logic [1:0] {
		TSCS_IDLE = 2'b01,
		TSCS_SCAN = 2'b10
	} tscs_state_t;

endpackage

// ---- tscs_top.sv ----
// control, completion status and interrupt logic of the touch scan unit
`timescale 1ns/1ps
`default_nettype none
module tscs_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic hw_trigger,
	input wire logic scan_done,
	input wire logic [15:0] scan_count,
	output logic scan_start,
	output logic [3:0] electrode_channel_select,
	output logic current_source_swap,
	output logic touch_sense_enable,
	output logic prescale_ctrl,
	output logic irq
);

	// -----------------------------------------------------------
	// bus decode
	// -----------------------------------------------------------
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic acc;
	logic wr_fire;
	logic rd_fire;
	logic lane0;
	logic [7:0] wbyte;

	assign acc = wb_cyc_i & wb_stb_i;
	assign wr_fire = acc & wb_we_i & ack_q;
	assign rd_fire = acc & ~wb_we_i & ack_q;
	assign lane0 = wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	// -----------------------------------------------------------
	// register state
	// -----------------------------------------------------------
	logic enable_q;
	logic irq_en_q;
	logic stop_en_q;
	logic mode_q;
	logic eos_q;
	logic swap_q;
	logic [7:0] cs1_q;
	logic [3:0] chan_q;
	logic [15:0] count_q;
	logic cnt_hi_seen_q;
	logic cnt_lo_seen_q;
	logic [1:0] evt_stat_q;
	logic [1:0] evt_mask_q;
	logic start_q;
	tscs_pkg::tscs_state_t state_q;

	logic wr_cs0;
	logic wr_cs1;
	logic wr_cs3;
	logic wr_stat;
	logic wr_mask;
	logic rd_hi;
	logic rd_lo;

	assign wr_cs0 = wr_fire & lane0 & (wb_adr_i == tscs_pkg::IDX_CS0);
	assign wr_cs1 = wr_fire & lane0 & (wb_adr_i == tscs_pkg::IDX_CS1);
	assign wr_cs3 = wr_fire & lane0 & (wb_adr_i == tscs_pkg::IDX_CS3);
	assign wr_stat = wr_fire & lane0 & (wb_adr_i == tscs_pkg::IDX_EVT_STAT);
	assign wr_mask = wr_fire & lane0 & (wb_adr_i == tscs_pkg::IDX_EVT_MASK);
	assign rd_hi = rd_fire & (wb_adr_i == tscs_pkg::IDX_CNT_HI);
	assign rd_lo = rd_fire & (wb_adr_i == tscs_pkg::IDX_CNT_LO);

	// -----------------------------------------------------------
	// trigger qualification
	// -----------------------------------------------------------
	logic busy;
	logic sw_trig;
	logic hw_trig;
	logic any_trig;
	logic start_ok;
	logic done_evt;

	assign busy = (state_q == tscs_pkg::TSCS_SCAN);
	assign done_evt = busy & scan_done;
	// software start only counts in software mode
	assign sw_trig = wr_cs0 & wbyte[tscs_pkg::B_SW_START]
		& (mode_q == tscs_pkg::MODE_SW);
	assign hw_trig = hw_trigger & (mode_q == tscs_pkg::MODE_HW);
	assign any_trig = sw_trig | hw_trig;
	assign start_ok = any_trig & enable_q & ~eos_q & ~busy;

	// -----------------------------------------------------------
	// bus handshake and read data
	// -----------------------------------------------------------
	// ack one cycle after the request, for one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc & ~ack_q;
		end
	end

	always_comb begin
		rdat_d = 32'h00000000;
		unique case (wb_adr_i)
			tscs_pkg::IDX_CS0: begin
				rdat_d[tscs_pkg::B_ENABLE] = enable_q;
				rdat_d[tscs_pkg::B_IRQ_EN] = irq_en_q;
				rdat_d[tscs_pkg::B_STOP_EN] = stop_en_q;
				rdat_d[tscs_pkg::B_TRIG_MODE] = mode_q;
				rdat_d[tscs_pkg::B_IN_PROG] = busy;
				rdat_d[tscs_pkg::B_EOS] = eos_q;
				rdat_d[tscs_pkg::B_SWAP] = swap_q;
				rdat_d[tscs_pkg::B_SW_START] = 1'b0;
			end
			tscs_pkg::IDX_CS1: begin
				rdat_d[7:0] = cs1_q;
			end
			tscs_pkg::IDX_CS3: begin
				rdat_d[3:0] = chan_q;
			end
			tscs_pkg::IDX_CNT_HI: begin
				rdat_d[7:0] = count_q[15:8];
			end
			tscs_pkg::IDX_CNT_LO: begin
				rdat_d[7:0] = count_q[7:0];
			end
			tscs_pkg::IDX_EVT_STAT: begin
				rdat_d[1:0] = evt_stat_q;
			end
			tscs_pkg::IDX_EVT_MASK: begin
				rdat_d[1:0] = evt_mask_q;
			end
			default: begin
				rdat_d = 32'h00000000;
			end
		endcase
	end

	// read data taken with the request, held until the next
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdat_q <= 32'h00000000;
		end else if (acc & ~ack_q) begin
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// -----------------------------------------------------------
	// control fields
	// -----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
			irq_en_q <= 1'b0;
			stop_en_q <= 1'b0;
			mode_q <= tscs_pkg::MODE_SW;
			swap_q <= 1'b0;
		end else if (wr_cs0) begin
			enable_q <= wbyte[tscs_pkg::B_ENABLE];
			irq_en_q <= wbyte[tscs_pkg::B_IRQ_EN];
			stop_en_q <= wbyte[tscs_pkg::B_STOP_EN];
			mode_q <= wbyte[tscs_pkg::B_TRIG_MODE];
			swap_q <= wbyte[tscs_pkg::B_SWAP];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs1_q <= tscs_pkg::RST_BYTE;
		end else if (wr_cs1) begin
			cs1_q <= wbyte;
		end
	end

	// channel is held steady while a scan runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chan_q <= tscs_pkg::RST_CH;
		end else if (wr_cs3 & ~busy) begin
			chan_q <= wbyte[3:0];
		end
	end

	// -----------------------------------------------------------
	// scan sequencing
	// -----------------------------------------------------------
	// busy from accept until the engine reports done
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= tscs_pkg::TSCS_IDLE;
		end else begin
			unique case (state_q)
				tscs_pkg::TSCS_IDLE: begin
					if (start_ok) begin
						state_q <= tscs_pkg::TSCS_SCAN;
					end
				end
				tscs_pkg::TSCS_SCAN: begin
					if (scan_done) begin
						state_q <= tscs_pkg::TSCS_IDLE;
					end
				end
				default: begin
					state_q <= tscs_pkg::TSCS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start_ok;
		end
	end

	// result kept until the next scan ends
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= tscs_pkg::RST_COUNT;
		end else if (done_evt) begin
			count_q <= scan_count;
		end
	end

	// -----------------------------------------------------------
	// end-of-scan flag and count read tracking
	// -----------------------------------------------------------
	logic eos_clear;

	// clear ignored unless both count bytes were read
	assign eos_clear = wr_cs0 & wbyte[tscs_pkg::B_EOS] & eos_q
		& cnt_hi_seen_q & cnt_lo_seen_q;

	// a finishing scan wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eos_q <= 1'b0;
		end else if (done_evt) begin
			eos_q <= 1'b1;
		end else if (eos_clear) begin
			eos_q <= 1'b0;
		end
	end

	// count reads only tracked while the flag is set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_hi_seen_q <= 1'b0;
			cnt_lo_seen_q <= 1'b0;
		end else if (~eos_q | eos_clear) begin
			cnt_hi_seen_q <= 1'b0;
			cnt_lo_seen_q <= 1'b0;
		end else begin
			if (rd_hi) begin
				cnt_hi_seen_q <= 1'b1;
			end
			if (rd_lo) begin
				cnt_lo_seen_q <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------
	// interrupt events
	// -----------------------------------------------------------
	logic [1:0] evt_set;

	assign evt_set[tscs_pkg::EV_DONE] = done_evt;
	assign evt_set[tscs_pkg::EV_DROP] = any_trig & ~start_ok;

	// sticky events, a new event wins over a clear
	generate
		for (genvar i = 0; i < tscs_pkg::EVT_W; i++) begin : g_evt
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					evt_stat_q[i] <= 1'b0;
				end else if (evt_set[i]) begin
					evt_stat_q[i] <= 1'b1;
				end else if (wr_stat & wbyte[i]) begin
					evt_stat_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_mask_q <= tscs_pkg::RST_EVT;
		end else if (wr_mask) begin
			evt_mask_q <= wbyte[1:0];
		end
	end

	// -----------------------------------------------------------
	// registered data outputs
	// -----------------------------------------------------------
	logic prescale_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale_q <= 1'b0;
		end else if (wr_cs1) begin
			prescale_q <= |wbyte;
		end
	end

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	assign irq = (eos_q & irq_en_q) | (|(evt_stat_q & evt_mask_q));
	assign scan_start = start_q;
	assign electrode_channel_select = chan_q;
	assign current_source_swap = swap_q;
	assign touch_sense_enable = enable_q;
	assign prescale_ctrl = prescale_q;

endmodule // tscs_top
`default_nettype wire

// ---- tscs_checker.sv ----
// port assertions of the touch scan control block
`timescale 1ns/1ps
`default_nettype none
module tscs_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic hw_trigger,
	input wire logic scan_done,
	input wire logic scan_start,
	input wire logic [3:0] electrode_channel_select,
	input wire logic current_source_swap,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic busy_q, eos_q, hi_q, lo_q, en_q, ien_q, mode_q, wr0, wr3, rd0, rd, idle;
	assign rd = wb_ack_o && !wb_we_i;
	assign rd0 = rd && wb_adr_i == tscs_pkg::IDX_CS0;
	assign wr0 = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == tscs_pkg::IDX_CS0;
	assign wr3 = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == tscs_pkg::IDX_CS3;
	assign idle = en_q && !eos_q && !busy_q && !scan_start;
	// shadow of flag, count reads and control bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{busy_q, eos_q, hi_q, lo_q, en_q, ien_q, mode_q} <= 7'h00;
		end else begin
			busy_q <= scan_start || (busy_q && !scan_done);
			eos_q <= (scan_done && busy_q) || (eos_q && !(wr0 && wb_dat_i[2] && hi_q && lo_q));
			hi_q <= eos_q && (hi_q || (rd && wb_adr_i == tscs_pkg::IDX_CNT_HI));
			lo_q <= eos_q && (lo_q || (rd && wb_adr_i == tscs_pkg::IDX_CNT_LO));
			if (wr0) begin
				{en_q, ien_q, mode_q} <= {wb_dat_i[7], wb_dat_i[6], wb_dat_i[4]};
			end
		end
	end
	property p_flag; rd0 |-> wb_dat_o[2] == $past(eos_q); endproperty
	a_flag: assert property (p_flag) else $error("flag read wrong");
	property p_wo; rd0 |-> !wb_dat_o[0]; endproperty
	a_wo: assert property (p_wo) else $error("start bit read as one");
	property p_irq; eos_q && ien_q |-> irq; endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_block; eos_q |-> !scan_start; endproperty
	a_block: assert property (p_block) else $error("start while flag set");
	property p_swap; wr0 |=> current_source_swap == $past(wb_dat_i[1]); endproperty
	a_swap: assert property (p_swap) else $error("swap bit wrong");
	property p_sw; wr0 && wb_dat_i[0] && wb_dat_i[7] && !wb_dat_i[4] && !mode_q && idle |=> scan_start;
	endproperty
	a_sw: assert property (p_sw) else $error("software start lost");
	property p_hw; hw_trigger && mode_q && idle |=> scan_start; endproperty
	a_hw: assert property (p_hw) else $error("hardware start lost");
	property p_ch; wr3 && !busy_q && !scan_start |=> electrode_channel_select == $past(wb_dat_i[3:0]);
	endproperty
	a_ch: assert property (p_ch) else $error("channel wrong");
	c_irq: cover property (eos_q && ien_q && irq);
	c_hw: cover property (hw_trigger && mode_q && idle ##1 scan_start);
	c_clr: cover property (eos_q ##1 !eos_q);
endmodule // tscs_checker
bind tscs_top tscs_checker chk_u (.clk(clk), .rst_n(rst_n), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .hw_trigger(hw_trigger), .scan_done(scan_done),
	.scan_start(scan_start), .electrode_channel_select(electrode_channel_select),
	.current_source_swap(current_source_swap), .irq(irq));
`default_nettype wire

// ---- tscs_engine_model.sv ----
// scan engine and oscillator model facing the touch scan block
`timescale 1ns/1ps
`default_nettype none
module tscs_engine_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic scan_start,
	input wire logic [3:0] electrode_channel_select,
	output logic scan_done,
	output logic [15:0] scan_count
);
	logic [5:0] cnt_q;
	logic [3:0] ch_q;
	logic [15:0] res;
	assign res = {ch_q, 4'h9, ~ch_q, 4'h6};
	// result only valid in the done cycle
	assign scan_count = scan_done ? res : ~res;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 6'h00;
			ch_q <= 4'h0;
			scan_done <= 1'b0;
		end else begin
			scan_done <= cnt_q == 6'h01;
			if (scan_start) begin
				ch_q <= electrode_channel_select;
				cnt_q <= slow ? 6'h28 : 6'h02;
			end else if (cnt_q != 6'h00) begin
				cnt_q <= cnt_q - 6'h01;
			end
		end
	end
endmodule // tscs_engine_model
`default_nettype wire

// ---- tscs_bench.sv ----
// self-checking bench of the touch scan control block
`timescale 1ns/1ps
`default_nettype none
module tscs_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic hw = 1'b0;
	logic slow = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] seed = 32'h37A7;
	logic ack, done, start, swap, irq, ena, pre;
	logic [15:0] cnt;
	logic [3:0] ch;
	int failures = 0, cmp_count = 0, starts = 0, cycles = 0;
	always #5 clk = ~clk;
	tscs_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.hw_trigger(hw), .scan_done(done), .scan_count(cnt), .scan_start(start),
		.electrode_channel_select(ch), .current_source_swap(swap), .touch_sense_enable(ena),
		.prescale_ctrl(pre), .irq(irq));
	tscs_engine_model eng_u (.clk(clk), .rst_n(rst_n), .slow(slow), .scan_start(start),
		.electrode_channel_select(ch), .scan_done(done), .scan_count(cnt));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] exp_cnt(input logic [3:0] c);
		return {c, 4'h9, ~c, 4'h6};
	endfunction
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
	endtask
	task automatic pulse();
		@(posedge clk);
		hw <= 1'b1;
		@(posedge clk);
		hw <= 1'b0;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (start === 1'b1) starts++;
		if (cycles == 6000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		logic [7:0] q, hi, lo, cfg;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, tscs_pkg::IDX_CS0, 8'h00, q);
		chk("cs0 reset", 16'(tscs_pkg::RST_BYTE), 16'(q));
		chk("prescale reset", 16'h0, 16'(pre));
		chk("enable reset", 16'h0, 16'(ena));
		bus(1'b1, tscs_pkg::IDX_CS1, 8'hA5, q);
		bus(1'b0, tscs_pkg::IDX_CS1, 8'h00, q);
		chk("cs1", 16'hA5, 16'(q));
		chk("prescale", 16'h1, 16'(pre));
		bus(1'b1, tscs_pkg::IDX_CS1, 8'h00, q);
		bus(1'b1, 8'h3F, 8'hFF, q);
		bus(1'b0, 8'h3F, 8'h00, q);
		chk("unmapped", 16'h0, 16'(q));
		chk("prescale off", 16'h0, 16'(pre));
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			slow <= seed[6];
			// first two passes pin down both trigger modes
			cfg = {1'b1, seed[5] | (i == 0), seed[7], (i < 2) ? i[0] : seed[4], 4'h0};
			bus(1'b1, tscs_pkg::IDX_CS3, {4'h0, seed[3:0]}, q);
			bus(1'b1, tscs_pkg::IDX_CS0, cfg, q);
			bus(1'b0, tscs_pkg::IDX_CS0, 8'h00, q);
			chk("cs0 fields", 16'({cfg[7:4], 4'h0}), 16'(q));
			chk("enable", 16'(cfg[7]), 16'(ena));
			if (cfg[4]) pulse();
			else bus(1'b1, tscs_pkg::IDX_CS0, cfg | 8'h01, q);
			q = 8'h00;
			for (int k = 0; k < 30 && !q[2]; k++) bus(1'b0, tscs_pkg::IDX_CS0, 8'h00, q);
			#1 chk("irq set", 16'(cfg[6]), 16'(irq));
			chk("flag", 16'h1, 16'(q[2]));
			chk("start bit", 16'h0, 16'(q[0]));
			pulse();
			bus(1'b1, tscs_pkg::IDX_CS0, cfg & 8'hEF | 8'h05, q);
			bus(1'b0, tscs_pkg::IDX_CNT_HI, 8'h00, hi);
			bus(1'b1, tscs_pkg::IDX_CS0, cfg & 8'hEF | 8'h04, q);
			bus(1'b0, tscs_pkg::IDX_CS0, 8'h00, q);
			chk("flag kept", 16'h1, 16'(q[2]));
			bus(1'b0, tscs_pkg::IDX_CNT_LO, 8'h00, lo);
			chk("count", exp_cnt(seed[3:0]), {hi, lo});
			bus(1'b1, tscs_pkg::IDX_CS0, cfg & 8'hEF | 8'h04, q);
			bus(1'b0, tscs_pkg::IDX_CS0, 8'h00, q);
			chk("flag clear", 16'h0, 16'(q[2]));
			chk("irq clear", 16'h0, 16'(irq));
			chk("starts", 16'(i + 1), 16'(starts));
			chk("swap", 16'h0, 16'(swap));
		end
		bus(1'b0, tscs_pkg::IDX_EVT_STAT, 8'h00, q);
		chk("events", 16'h3, 16'(q));
		bus(1'b1, tscs_pkg::IDX_EVT_MASK, 8'h03, q);
		#1 chk("irq mask", 16'h1, 16'(irq));
		bus(1'b1, tscs_pkg::IDX_EVT_STAT, 8'h03, q);
		#1 chk("irq w1c", 16'h0, 16'(irq));
		wrap_up();
	end
endmodule // tscs_bench
`default_nettype wire
